// *** hw/apctc_pkg.sv ***
// constants for the apc timing and configuration register slice
package apctc_pkg;
  // register offsets on the password-2 page
  localparam logic [7:0] OFS_VERSION     = 8'h87;
  localparam logic [7:0] OFS_SAMPLE_RATE = 8'h88;
  localparam logic [7:0] OFS_CONFIG      = 8'h89;
  localparam logic [7:0] OFS_STEP_LIMIT  = 8'h8a;
  // reset values
  localparam logic [7:0] RST_SAMPLE_RATE = 8'h00;
  localparam logic [7:0] RST_CONFIG      = 8'h00;
  localparam logic [7:0] RST_STEP_LIMIT  = 8'h00;
  // field positions
  localparam int RATE_CODE_MSB    = 3;
  localparam int CFG_GATE_POL_BIT = 7;
  localparam int CFG_LATCH_BIT    = 6;
  localparam int CFG_ADDRESS_SOURCE_SELECT_BIT     = 4;
  localparam int STEP_SHIFT       = 5;    // step byte weights 2^12..2^5
  // fixed slave address used while address select is clear
  localparam logic [7:0] FIXED_SLAVE_ADDR = 8'ha2;
  // widths
  localparam int BIAS_W   = 13;
  localparam int ALARM_N  = 8;
  localparam int CNT_W    = 10;
  // sample timing
  localparam logic [3:0] RATE_CODE_MAX = 4'h9;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FIRST_NS [10] = '{350, 550, 750, 950, 1350, 1550, 1750, 2150, 2950, 3150};
  localparam int REP_NS   [10] = '{800, 1200, 1600, 2000, 2800, 3200, 3600, 4400, 6000, 6400};

  // least time to first sample, rounded up to whole cycles
  function automatic logic [CNT_W-1:0] first_cycles(input logic [3:0] code);
    int ns;
    ns = FIRST_NS[int'(code)];
    return CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  // repeat period in cycles, rounded down
  function automatic logic [CNT_W-1:0] rep_cycles(input logic [3:0] code);
    int ns;
    ns = REP_NS[int'(code)];
    return CNT_W'(ns / CLK_PERIOD_NS);
  endfunction
endpackage

// *** hw/apctc_timer_if.sv ***
// carrier between the register bank and the apc sample timer
`timescale 1ns/100ps
interface apctc_timer_if;
  logic       burst_level; // synchronised burst enable
  logic [3:0] rate_code;   // raw sample rate code from the register
  logic       sample;      // one-cycle apc comparison strobe

  modport ctrl (output burst_level, output rate_code, input sample);
  modport tmr  (input burst_level, input rate_code, output sample);
endinterface

// *** hw/apctc_sample_timer.sv ***
// apc comparison sample timer: first-sample delay then fixed repeat period
`timescale 1ns/100ps
module apctc_sample_timer (
  input  wire logic   i_mclk,
  input  wire logic   i_rst_n,
  apctc_timer_if.tmr  tif
);
  localparam int CNT_W       = apctc_pkg::CNT_W;                                  // counter width
  localparam int REP_MAX_CYC = int'(apctc_pkg::rep_cycles(apctc_pkg::RATE_CODE_MAX)); // top code period

  logic                       burst_prev; // last burst level, for rise detect
  logic                       running;    // timer armed during a burst
  logic [apctc_pkg::CNT_W-1:0] cnt;       // cycles left to next sample
  logic [3:0]                 eff_code;   // code after clamping
  logic                       sample;     // strobe flop

  // codes above the top entry behave as the top entry
  always_comb begin
    eff_code = (tif.rate_code > apctc_pkg::RATE_CODE_MAX) ? apctc_pkg::RATE_CODE_MAX : tif.rate_code;
  end

  // rise detect on the already synchronised level
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      burst_prev <= 1'b0;
    end else begin
      burst_prev <= tif.burst_level;
    end
  end

  // countdown: restart on each rise, cancel when burst drops
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      running <= 1'b0;
      cnt     <= '0;
      sample  <= 1'b0;
    end else if (!tif.burst_level) begin
      running <= 1'b0;
      sample  <= 1'b0;
    end else if (!burst_prev) begin
      running <= 1'b1;
      cnt     <= apctc_pkg::first_cycles(eff_code) - 1'b1;
      sample  <= 1'b0;
    end else if (running && cnt == '0) begin
      sample  <= 1'b1;
      cnt     <= apctc_pkg::rep_cycles(eff_code) - 1'b1;
    end else begin
      sample  <= 1'b0;
      cnt     <= running ? cnt - 1'b1 : cnt;
    end
  end

  assign tif.sample = sample;

  // helper: cycles since the rise and since the last strobe
  logic [apctc_pkg::CNT_W-1:0] dv_since;
  logic                        dv_first;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dv_since <= '0;
      dv_first <= 1'b0;
    end else if (tif.burst_level && !burst_prev) begin
      dv_since <= '0;
      dv_first <= 1'b1;
    end else begin
      dv_since <= sample ? CNT_W'(1) : dv_since + 1'b1;
      dv_first <= dv_first && !sample;
    end
  end
  AST_FIRST_EXACT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sample && dv_first && $stable(eff_code) |-> dv_since == apctc_pkg::first_cycles(eff_code))
    else $error("first apc sample not at programmed delay");
  AST_REP_PERIOD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sample && !dv_first && $stable(eff_code) |-> dv_since == apctc_pkg::rep_cycles(eff_code))
    else $error("apc repeat period wrong");
  AST_CODE_CLAMP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sample && !dv_first && tif.rate_code > apctc_pkg::RATE_CODE_MAX && $stable(tif.rate_code) |->
      dv_since == REP_MAX_CYC)
    else $error("high rate code not clamped");
  AST_CANCEL: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !tif.burst_level |=> !sample ##1 !sample)
    else $error("sample after burst end");
  COV_FIRST: cover property (@(posedge i_mclk) disable iff (!i_rst_n) sample && dv_first);
  COV_REPEAT: cover property (@(posedge i_mclk) disable iff (!i_rst_n) sample && !dv_first);
endmodule

// *** hw/apctc_regs.sv ***
// apc timing / output polarity / address / bias step register bank
`timescale 1ns/100ps

module apctc_regs #(
  parameter logic [7:0] VERSION_VALUE = 8'h01 // arbitrary version value
) (
  input  wire logic                            i_mclk,
  input  wire logic                            i_rst_n,
  // register access from the serial front end
  input  wire logic                            i_reg_wr,
  input  wire logic                            i_reg_rd,
  input  wire logic [7:0]                      i_reg_addr,
  input  wire logic [7:0]                      i_reg_wdata,
  input  wire logic                            i_level_two_password,
  output logic      [7:0]                      o_reg_rdata,
  // shadow eeprom handling
  input  wire logic                            i_shadow_eeprom_write_block,
  output logic                                 o_eeprom_wr,
  output logic      [7:0]                      o_eeprom_addr,
  output logic      [7:0]                      o_eeprom_data,
  // slave address selection
  input  wire logic [7:0]                      i_device_address,
  output logic      [7:0]                      o_slave_addr,
  // burst enable pin and apc strobe
  input  wire logic                            i_burst_enable_in,
  output logic                                 o_apc_sample,
  // fault management
  input  wire logic                            i_tx_disable,
  input  wire logic [apctc_pkg::ALARM_N-1:0]   i_alarm,
  input  wire logic [apctc_pkg::ALARM_N-1:0]   i_alarm_txf_en,
  input  wire logic                            i_supply_low_gate_en,
  input  wire logic                            i_supply_low_fault_en,
  input  wire logic                            i_supply_above_done,
  input  wire logic                            i_gate_shutdown,
  output logic                                 o_laser_switch_gate,
  output logic                                 o_tx_fault,
  // startup bias stepping
  input  wire logic                            i_startup,
  input  wire logic                            i_bias_step,
  input  wire logic [apctc_pkg::BIAS_W-1:0]    i_bias_target,
  output logic      [apctc_pkg::BIAS_W-1:0]    o_laser_bias_output
);
  localparam int AN = apctc_pkg::ALARM_N;
  localparam int BW = apctc_pkg::BIAS_W;

  // register storage (volatile copies of the shadowed bytes)
  logic [3:0] apc_sample_rate_code;  // sample rate code
  logic [7:0] cfg;                   // polarity / latch / address select
  logic [7:0] step_limit;            // startup step limit

  // pin synchronisers; burst logic uses only the second stage, transmit disable uses the second and third
  logic burst_s1, burst_s2;
  logic txd_s1, txd_s2, txd_s3;

  // fault latching state
  logic          supply_ok_seen;     // first good supply reading done
  logic          supply_low_used;    // supply-low alarm routed somewhere
  logic          latch_allow;        // latching permitted now
  logic          txd_edge;           // any transmit disable transition
  logic [AN-1:0] alarm_masked;       // alarms enabled onto the fault pin
  logic [AN-1:0] latched;            // held alarm states
  logic [AN-1:0] fault_src;          // per-alarm contribution

  // write qualifier: password access required for every byte here
  logic wr_ok;
  assign wr_ok = i_reg_wr && i_level_two_password;

  // carrier to the sample timer
  apctc_timer_if u_tif ();

  // ---------------- register writes ----------------

  // writable bytes; version offset is simply not decoded for writes
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      apc_sample_rate_code <= apctc_pkg::RST_SAMPLE_RATE[apctc_pkg::RATE_CODE_MSB:0];
      cfg                  <= apctc_pkg::RST_CONFIG;
      step_limit           <= apctc_pkg::RST_STEP_LIMIT;
    end else if (wr_ok) begin
      case (i_reg_addr)
        apctc_pkg::OFS_SAMPLE_RATE: begin
          apc_sample_rate_code <= i_reg_wdata[apctc_pkg::RATE_CODE_MSB:0];
        end
        apctc_pkg::OFS_CONFIG: begin
          cfg <= i_reg_wdata;
        end
        apctc_pkg::OFS_STEP_LIMIT: begin
          step_limit <= i_reg_wdata;
        end
        default: begin
          // version and unmapped offsets: writes dropped
        end
      endcase
    end
  end

  // eeprom commit request for shadowed bytes unless blocked
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_eeprom_wr   <= 1'b0;
      o_eeprom_addr <= 8'h00;
      o_eeprom_data <= 8'h00;
    end else begin
      o_eeprom_wr <= wr_ok && !i_shadow_eeprom_write_block &&
                     (i_reg_addr == apctc_pkg::OFS_SAMPLE_RATE ||
                      i_reg_addr == apctc_pkg::OFS_CONFIG ||
                      i_reg_addr == apctc_pkg::OFS_STEP_LIMIT);
      if (wr_ok) begin
        o_eeprom_addr <= i_reg_addr;
        // rate byte stored with its upper nibble forced to zero
        o_eeprom_data <= (i_reg_addr == apctc_pkg::OFS_SAMPLE_RATE) ? {4'h0, i_reg_wdata[3:0]} : i_reg_wdata;
      end
    end
  end

  // ---------------- register reads ----------------

  // read data registered one cycle after the read strobe; holds between reads
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      if (!i_level_two_password) begin
        o_reg_rdata <= 8'h00;          // no password, nothing visible
      end else begin
        case (i_reg_addr)
          apctc_pkg::OFS_VERSION:     o_reg_rdata <= VERSION_VALUE;
          apctc_pkg::OFS_SAMPLE_RATE: o_reg_rdata <= {4'h0, apc_sample_rate_code};
          apctc_pkg::OFS_CONFIG:      o_reg_rdata <= cfg;
          apctc_pkg::OFS_STEP_LIMIT:  o_reg_rdata <= step_limit;
          default:                    o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ---------------- slave address ----------------

  // address select picks fixed or programmed main-memory address
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_slave_addr <= apctc_pkg::FIXED_SLAVE_ADDR;
    end else if (cfg[apctc_pkg::CFG_ADDRESS_SOURCE_SELECT_BIT]) begin
      o_slave_addr <= i_device_address;
    end else begin
      o_slave_addr <= apctc_pkg::FIXED_SLAVE_ADDR;
    end
  end

  // ---------------- burst enable and apc sampling ----------------

  // two-flop synchroniser for the burst enable pin
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      burst_s1 <= 1'b0;
      burst_s2 <= 1'b0;
    end else begin
      burst_s1 <= i_burst_enable_in;
      burst_s2 <= burst_s1;
    end
  end
  // the synchroniser costs two cycles, well inside the 50 ns tolerance

  assign u_tif.burst_level = burst_s2;
  assign u_tif.rate_code   = apc_sample_rate_code;

  apctc_sample_timer u_timer (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .tif     (u_tif.tmr)
  );

  // retime the strobe so the port comes straight from a flop
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_apc_sample <= 1'b0;
    end else begin
      o_apc_sample <= u_tif.sample && burst_s2;
    end
  end

  // ---------------- fault handling ----------------

  // transmit disable pin: two-flop sync plus one stage for edge detect
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      txd_s1 <= 1'b0;
      txd_s2 <= 1'b0;
      txd_s3 <= 1'b0;
    end else begin
      txd_s1 <= i_tx_disable;
      txd_s2 <= txd_s1;
      txd_s3 <= txd_s2;
    end
  end
  assign txd_edge = txd_s2 ^ txd_s3;

  // slow power-on: remember the first supply reading above the low set point
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      supply_ok_seen <= 1'b0;
    end else if (i_supply_above_done) begin
      supply_ok_seen <= 1'b1;
    end
  end

  assign supply_low_used = i_supply_low_gate_en || i_supply_low_fault_en;
  assign latch_allow     = cfg[apctc_pkg::CFG_LATCH_BIT] && (supply_ok_seen || !supply_low_used);
  assign alarm_masked    = i_alarm & i_alarm_txf_en;

  // per-alarm latch; a new alarm wins over a disable transition
  genvar gi;
  generate
    for (gi = 0; gi < AN; gi++) begin : g_alarm
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          latched[gi] <= 1'b0;
        end else if (!latch_allow) begin
          latched[gi] <= 1'b0;
        end else begin
          latched[gi] <= alarm_masked[gi] || (latched[gi] && !txd_edge);
        end
      end
      assign fault_src[gi] = alarm_masked[gi] || (latched[gi] && latch_allow);
    end
  endgenerate

  // wired-or of enabled (and possibly held) alarm states
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_fault <= 1'b0;
    end else begin
      o_tx_fault <= |fault_src;
    end
  end

  // switch gate: rest level is the polarity bit, shutdown inverts it
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_laser_switch_gate <= 1'b0;
    end else begin
      o_laser_switch_gate <= cfg[apctc_pkg::CFG_GATE_POL_BIT] ^ i_gate_shutdown;
    end
  end

  // ---------------- startup bias stepping ----------------

  logic          bias_up;     // target above current output
  logic [BW-1:0] bias_mag;    // distance to target
  logic [BW-1:0] bias_lim;    // largest move allowed per step
  logic [BW-1:0] bias_move;   // move taken this step

  // limit the move; zero step byte means single-lsb creep
  always_comb begin
    bias_up   = i_bias_target > o_laser_bias_output;
    bias_mag  = bias_up ? i_bias_target - o_laser_bias_output : o_laser_bias_output - i_bias_target;
    bias_lim  = (step_limit == 8'h00) ? BW'(1) : {step_limit, 5'h00};
    bias_move = (bias_mag < bias_lim) ? bias_mag : bias_lim;
  end

  // outside startup the output tracks the target directly
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_laser_bias_output <= '0;
    end else if (!i_startup) begin
      o_laser_bias_output <= i_bias_target;
    end else if (i_bias_step) begin
      o_laser_bias_output <= bias_up ? o_laser_bias_output + bias_move
                                     : o_laser_bias_output - bias_move;
    end
  end

  // ---------------- checks ----------------

  AST_VERSION_READ: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_reg_rd && i_level_two_password && i_reg_addr == 8'h87 |=> o_reg_rdata == VERSION_VALUE)
    else $error("version byte not fixed");
  AST_RATE_UPPER_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_reg_rd && i_reg_addr == 8'h88 |=> o_reg_rdata[7:4] == 4'h0)
    else $error("rate byte upper nibble not zero");
  AST_GATE_REST: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !i_gate_shutdown |=> o_laser_switch_gate == $past(cfg[7]))
    else $error("switch gate not at rest polarity");
  AST_FAULT_OR: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    |alarm_masked |=> o_tx_fault)
    else $error("enabled alarm missing from fault output");
  AST_LATCH_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    latch_allow && |latched && !txd_edge ##1 latch_allow |-> ##1 o_tx_fault)
    else $error("latched fault dropped");
  AST_NO_LATCH_EARLY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    supply_low_used && !supply_ok_seen |=> latched == '0)
    else $error("alarm latched before good supply");
  AST_ADDR_FIXED: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !cfg[4] |=> o_slave_addr == 8'ha2)
    else $error("fixed slave address not used");
  AST_ADDR_PROG: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    cfg[4] |=> o_slave_addr == $past(i_device_address))
    else $error("programmed slave address not used");
  AST_STEP_LIMIT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_startup && i_bias_step && step_limit != 8'h00 |=>
      (o_laser_bias_output - $past(o_laser_bias_output) <= {$past(step_limit), 5'h00}) ||
      ($past(o_laser_bias_output) - o_laser_bias_output <= {$past(step_limit), 5'h00}))
    else $error("startup bias step too large");
  AST_STEP_LSB: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_startup && i_bias_step && step_limit == 8'h00 && i_bias_target != o_laser_bias_output |=>
      (o_laser_bias_output == $past(o_laser_bias_output) + 13'h0001) ||
      (o_laser_bias_output == $past(o_laser_bias_output) - 13'h0001))
    else $error("zero step byte not single lsb");
  AST_SEE_BLOCK: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_shadow_eeprom_write_block |=> !o_eeprom_wr)
    else $error("eeprom write while blocked");
  COV_LATCHED: cover property (@(posedge i_mclk) disable iff (!i_rst_n) latch_allow && |latched);
  COV_PROG_ADDR: cover property (@(posedge i_mclk) disable iff (!i_rst_n) cfg[4]);
  COV_STEP: cover property (@(posedge i_mclk) disable iff (!i_rst_n) i_startup && i_bias_step);
endmodule

// *** dv/apctc_host_model.sv ***
// host side model: byte strobe register access behind the serial front end
`timescale 1ns/100ps
module apctc_host_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  // idle bus at time zero, no strobe before reset release
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // one-cycle write strobe; request held until the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_mclk);
    o_wr <= 1'b0;
  endtask
  // read strobe, data taken one cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge i_mclk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    @(posedge i_mclk);
    #1;
    q = i_rdata;
  endtask
endmodule

// *** dv/test_apctc_regs.sv ***
// self-checking bench for the apc timing and configuration register bank
`timescale 1ns/100ps
module test_apctc_regs;
  localparam logic [7:0] VER = 8'h3c; // arbitrary version value
  logic i_mclk = 1'b0, i_rst_n = 1'b0, wr, rd, ew, smp, gate, flt;
  logic pw = 1'b1, seb = 1'b0, burst_enable_in = 1'b0, txd = 1'b0, slg = 1'b0, slf = 1'b0;
  logic sad = 1'b0, gsd = 1'b0, st = 1'b0, bs = 1'b0;
  logic [7:0] addr, wd, q, rdat, ea, ed, sa, dev = 8'h5c, al = 8'h00, alen = 8'h00;
  logic [apctc_pkg::BIAS_W-1:0] tgt = 13'h0000, bias;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  initial forever #5 i_mclk = ~i_mclk;
  apctc_host_model host (.i_mclk(i_mclk), .i_rdata(rdat), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wd));
  apctc_regs #(.VERSION_VALUE(VER)) uut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wd), .i_level_two_password(pw), .o_reg_rdata(rdat),
    .i_shadow_eeprom_write_block(seb), .o_eeprom_wr(ew), .o_eeprom_addr(ea), .o_eeprom_data(ed),
    .i_device_address(dev), .o_slave_addr(sa), .i_burst_enable_in(burst_enable_in), .o_apc_sample(smp),
    .i_tx_disable(txd), .i_alarm(al), .i_alarm_txf_en(alen), .i_supply_low_gate_en(slg),
    .i_supply_low_fault_en(slf), .i_supply_above_done(sad), .i_gate_shutdown(gsd),
    .o_laser_switch_gate(gate), .o_tx_fault(flt), .i_startup(st), .i_bias_step(bs),
    .i_bias_target(tgt), .o_laser_bias_output(bias));
  // shared compare, four-state exact; wide enough for strobe plus address plus data
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // settle n edges, then step off the edge
  task automatic cy(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // reset values, read-only version, refused writes, eeprom commit
  task automatic t_regs();
    host.rd(8'h87, q); chk(q, VER);
    host.wr(8'h87, 8'hff); host.rd(8'h87, q); chk(q, VER);
    for (int a = 8'h88; a <= 8'h8a; a++) begin
      host.rd(8'(a), q); chk(q, 8'h00);
    end
    host.wr(8'h88, 8'h5a); #1 chk({ew, ea, ed}, {1'b1, 8'h88, 8'h0a});
    host.rd(8'h88, q); chk(q, 8'h0a);
    @(posedge i_mclk) seb <= 1'b1;
    host.wr(8'h88, 8'h03); #1 chk(ew, 1'b0);
    host.rd(8'h88, q); chk(q, 8'h03);
    @(posedge i_mclk) pw <= 1'b0;
    host.wr(8'h8a, 8'h11);
    @(posedge i_mclk) pw <= 1'b1;
    host.rd(8'h8a, q); chk(q, 8'h00);
    $display("done regs");
  endtask
  // first-sample delay window, repeat period, cancel on burst fall
  task automatic t_rate(input logic [7:0] code, input int f, input int p);
    int n;
    host.wr(8'h88, code);
    @(posedge i_mclk) burst_enable_in <= 1'b1;
    n = 0;
    do begin cy(1); n++; end while (smp !== 1'b1 && n < 2000);
    chk(n >= f - 5 && n <= f + 5, 1'b1);
    n = 0;
    do begin cy(1); n++; end while (smp !== 1'b1 && n < 2000);
    chk(n >= p - 1 && n <= p + 1, 1'b1);
    @(posedge i_mclk) burst_enable_in <= 1'b0;
    cy(4);
    n = 0;
    repeat (1000) begin cy(1); if (smp === 1'b1) n++; end
    chk(n, 0);
    $display("done rate %h", code);
  endtask
  // gate rest level follows the polarity bit; slave address source
  task automatic t_cfg();
    chk(sa, 8'ha2);
    host.wr(8'h89, 8'h90); cy(2); chk({gate, sa}, {1'b1, dev});
    @(posedge i_mclk) gsd <= 1'b1;
    cy(2); chk(gate, 1'b0);
    @(posedge i_mclk) gsd <= 1'b0;
    host.wr(8'h89, 8'h00); cy(2); chk({gate, sa}, {1'b0, 8'ha2});
    $display("done cfg");
  endtask
  // one-cycle alarm pulse on bit 0
  task automatic pulse_alarm();
    @(posedge i_mclk) al <= 8'h01;
    @(posedge i_mclk) al <= 8'h00;
    cy(3);
  endtask
  // fault or, latching, clear on disable edge, supply-low hold-off
  task automatic t_fault();
    @(posedge i_mclk) begin alen <= 8'h05; al <= 8'h04; end
    cy(2); chk(flt, 1'b1);
    @(posedge i_mclk) al <= 8'h02;
    cy(2); chk(flt, 1'b0);
    pulse_alarm(); chk(flt, 1'b0);
    host.wr(8'h89, 8'h40);
    @(posedge i_mclk) slf <= 1'b1;
    pulse_alarm(); chk(flt, 1'b0);
    @(posedge i_mclk) sad <= 1'b1;
    @(posedge i_mclk) sad <= 1'b0;
    pulse_alarm(); chk(flt, 1'b1);
    @(posedge i_mclk) txd <= 1'b1;
    cy(6); chk(flt, 1'b0);
    $display("done fault");
  endtask
  // one bias step pulse during startup
  task automatic step();
    @(posedge i_mclk) bs <= 1'b1;
    @(posedge i_mclk) bs <= 1'b0;
    cy(1);
  endtask
  // startup stepping: single lsb at zero, then limited by step byte
  task automatic t_bias();
    @(posedge i_mclk) begin st <= 1'b1; tgt <= 13'h0100; end
    step(); chk(bias, 13'h0001);
    host.wr(8'h8a, 8'h02);
    step(); chk(bias, 13'h0041);
    step(); step(); step(); chk(bias, 13'h0100);
    $display("done bias");
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, well above the longest run
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_regs();
    t_rate(8'h00, 35, 80);
    t_rate(8'h0f, 315, 640);
    t_cfg();
    t_fault();
    t_bias();
    stop_test();
  end
endmodule
